// [shared/perf_monitor_regs.vh]
`ifndef PERF_MONITOR_REGS_VH
`define PERF_MONITOR_REGS_VH

// Register addresses (register index on the access port)
`define ADDR_P3_RES        12'h3F8
`define ADDR_P6_RES        12'h3F9
`define ADDR_SLEEP3_RES    12'h3FC
`define ADDR_SLEEP6_RES    12'h3FD
`define ADDR_CTL_BASE      12'h700
`define ADDR_CTR_BASE      12'h708
`define ADDR_BAND_FILTER   12'h710

// Counter control fields
`define CTL_EVSEL_HI       7
`define CTL_EVSEL_LO       0
`define CTL_OCC_FLAG_BIT   7
`define CTL_OCC_SEL_HI     15
`define CTL_OCC_SEL_LO     14
`define CTL_EDGE_BIT       18
`define CTL_ENABLE_BIT     22
`define CTL_THRESH_HI      28
`define CTL_THRESH_LO      24
`define CTL_OCC_INV_BIT    30
`define CTL_OCC_EDGE_BIT   31
`define CTL_WR_MASK        32'hDF44C0FF
`define CTL_RESET          32'h00000000

// Band filter fields
`define BAND_FILTER_MASK   64'h00000000FFFFFFFF
`define BAND_FILTER_RESET  32'h00000000
`define BAND_MHZ_STEP      100

// Event codes
`define EV_CLOCKTICKS      8'h00
`define EV_BAND0           8'h0B
`define EV_OCC_CORES       8'h80

// Widths and reset values
`define GEN_CTR_W          48
`define RES_CTR_W          64
`define INC_W              5
`define CTR_RESET          64'h0000000000000000

`endif

// [verilog/wrap_counter.v]
`timescale 1ns/1ps
`default_nettype none
`include "perf_monitor_regs.vh"

module wrap_counter #(
    parameter W = 48
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst,
    // Software load
    input  wire         load,
    input  wire [W-1:0] load_val,
    // Increment for this cycle
    input  wire [4:0]   inc,
    // Count
    output reg  [W-1:0] count_r
);

    wire [W-1:0] count_nxt;

    // Software write wins over the increment of the same cycle; sum wraps at W bits
    assign count_nxt = load ? load_val : count_r + {{(W-5){1'b0}}, inc}; // [R19] [R15]

    // Counter state
    always @(posedge clk_sys) begin
        if (rst) begin
            count_r <= {W{1'b0}};
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule
`default_nettype wire

// [verilog/event_qualify.v]
`timescale 1ns/1ps
`default_nettype none
`include "perf_monitor_regs.vh"

module event_qualify #(
    parameter OCC_W = 5
) (
    // Clock and reset
    input  wire               clk_sys,
    input  wire               rst,
    // Counter control
    input  wire [31:0]        ctrl,
    // Event sources
    input  wire [127:0]       simple_events,
    input  wire [3*OCC_W-1:0] occ_values,
    input  wire [3:0]         band_hit,
    // Increment for the counter
    output reg  [4:0]         incr
);

    reg  [4:0]  occ_val;
    reg         evt;
    reg         prev_r;
    wire [7:0]  sel      = ctrl[`CTL_EVSEL_HI:`CTL_EVSEL_LO];
    wire        is_occ   = sel[`CTL_OCC_FLAG_BIT];
    wire [4:0]  thr      = ctrl[`CTL_THRESH_HI:`CTL_THRESH_LO];
    wire        occ_inv  = ctrl[`CTL_OCC_INV_BIT];
    wire        occ_edge = ctrl[`CTL_OCC_EDGE_BIT];
    wire        gen_edge = ctrl[`CTL_EDGE_BIT];
    wire        enable   = ctrl[`CTL_ENABLE_BIT];
    wire        cmp_ge;
    wire        cond;
    wire        edge_src;
    wire [7:0]  band_off = sel - `EV_BAND0;

    // Occupancy source pick; select 0 means no source
    always @* begin
        case (ctrl[`CTL_OCC_SEL_HI:`CTL_OCC_SEL_LO])
            2'h1:    occ_val = occ_values[OCC_W-1:0];            // [R4]
            2'h2:    occ_val = occ_values[2*OCC_W-1:OCC_W];      // [R4]
            2'h3:    occ_val = occ_values[3*OCC_W-1:2*OCC_W];    // [R4]
            default: occ_val = 5'h00;
        endcase
    end

    // Plain event pick: clockticks, band hits, or the event bus
    always @* begin
        if (sel == `EV_CLOCKTICKS) begin
            evt = 1'b1;                                          // [R18]
        end else if (band_off < 8'h04) begin
            evt = band_hit[band_off[1:0]];                       // [R12]
        end else begin
            evt = simple_events[sel[6:0]];                       // [R1]
        end
    end

    // Threshold compare, optionally inverted; inversion only counts for occupancy codes
    assign cmp_ge   = (occ_val >= thr);                          // [R7]
    assign cond     = (is_occ && occ_inv) ? ~cmp_ge : cmp_ge;    // [R5] [R7]
    assign edge_src = is_occ ? cond : evt;

    // Increment selection. A zero limit without filters accumulates the raw value,
    // which is why the edge and invert filters need a nonzero limit.
    always @* begin
        if (!enable) begin
            incr = 5'h00;
        end else if (is_occ) begin
            if (thr == 5'h00 && !occ_inv && !occ_edge) begin
                incr = occ_val;                                  // [R2] [R17] [R9]
            end else if (occ_edge) begin
                // Rising edge of cond is a falling edge of the compare when inverted
                incr = {4'h0, cond & ~prev_r};                   // [R6] [R8] [R5]
            end else begin
                incr = {4'h0, cond};                             // [R6]
            end
        end else if (gen_edge) begin
            incr = {4'h0, evt & ~prev_r};                        // [R16]
        end else begin
            incr = {4'h0, evt};
        end
    end

    // Previous level for edge detection, tracked every cycle
    always @(posedge clk_sys) begin
        if (rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= edge_src;                                  // [R6] [R16]
        end
    end

endmodule
`default_nettype wire

// [verilog/power_ctrl_perf_counters.v]
// Behaviour
// [R1] Four 48-bit general counters, each programmed by its own control register.
// [R2] A general counter adds up to a five-bit value each cycle.
// [R3] Four separate 64-bit residency counters for performance and sleep states.
// [R4] Occupancy values from the microcontroller are captured for counting.
// [R5] Occupancy invert and edge controls act only when selector top bit is set.
// [R6] Occupancy edge bit 31 counts rising transitions; clear counts every true cycle.
// [R7] Occupancy invert bit 30: clear means value >= limit, set means value < limit.
// [R8] With invert and edge both set, count falling transitions of the compare.
// [R9] Software must program a nonzero limit, one for single-step events.
// [R10] Band filter holds four 8-bit bands at bits 31:0; bits 63:48 reserved.
// [R11] Band values are frequency multipliers in 100 MHz steps.
// [R12] All four bands are tracked at once by their own band events.
// [R13] Residency counters ignore monitor freeze and reset controls.
// [R14] Sleep residency adds one per cycle when any core is in that state.
// [R15] Each residency counter is a software-writable 64-bit field resetting to zero.
// [R16] General edge control turns cycle counting into transition counting.
// [R17] Occupancy event code 0x80 adds up to 31 per cycle on any counter.
// [R18] Event code 0x00 counts controller clock cycles while enabled.
// [R19] General counters wrap at 48 bits, residency counters at 64 bits.
`timescale 1ns/1ps
`default_nettype none
`include "perf_monitor_regs.vh"

module power_ctrl_perf_counters #(
    parameter NUM_CORES = 8,
    parameter OCC_W     = 5
) (
    // Clock and reset
    input  wire                 clk_sys,
    input  wire                 rst,
    // Register access port
    input  wire                 msr_wr_en,
    input  wire                 msr_rd_en,
    input  wire [11:0]          msr_addr,
    input  wire [63:0]          msr_wdata,
    output reg  [63:0]          msr_rdata_r,
    output reg                  msr_rvalid_r,
    output reg                  msr_err_r,
    // Microcontroller event sources
    input  wire [127:0]         simple_events,
    input  wire [3*OCC_W-1:0]   occ_values,
    input  wire [7:0]           freq_ratio,
    // Residency state inputs
    input  wire                 p_state3_active,
    input  wire                 p_state6_active,
    input  wire [NUM_CORES-1:0] cores_in_sleep3,
    input  wire [NUM_CORES-1:0] cores_in_sleep6
);

    reg  [31:0] ctrl_r [0:3];
    reg  [31:0] band_filter_r;
    reg  [63:0] rdata_nxt;
    reg         err_nxt;
    wire [47:0] gen_count [0:3];
    wire [63:0] res_count [0:3];
    wire [4:0]  gen_inc   [0:3];
    wire [3:0]  band_hit;
    wire [3:0]  res_active;
    wire [63:0] filt_rd;
    integer     k;

    // True when the access address falls in a block of four starting at base
    function in_quad;
        input [11:0] addr;
        input [11:0] base;
        begin
            in_quad = (addr[11:2] == base[11:2]) && (base[1:0] == 2'h0);
        end
    endfunction

    // Band hit: frequency ratio (100 MHz units) at or above each band value
    assign band_hit[0] = (freq_ratio >= band_filter_r[7:0]);     // [R11] [R12]
    assign band_hit[1] = (freq_ratio >= band_filter_r[15:8]);    // [R12]
    assign band_hit[2] = (freq_ratio >= band_filter_r[23:16]);   // [R12]
    assign band_hit[3] = (freq_ratio >= band_filter_r[31:24]);   // [R12]

    // Residency conditions; sleep counters count cycles with any core present
    assign res_active[0] = p_state3_active;                      // [R3]
    assign res_active[1] = p_state6_active;                      // [R3]
    assign res_active[2] = |cores_in_sleep3;                     // [R14]
    assign res_active[3] = |cores_in_sleep6;                     // [R14]

    // Upper filter half reads as zero, reserved bits included
    assign filt_rd = {32'h00000000, band_filter_r} & `BAND_FILTER_MASK; // [R10]

    // General counters and their qualifiers
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_ctr
            event_qualify #(
                .OCC_W(OCC_W)
            ) u_qual (
                .clk_sys       (clk_sys),
                .rst           (rst),
                .ctrl          (ctrl_r[g]),
                .simple_events (simple_events),
                .occ_values    (occ_values),
                .band_hit      (band_hit),
                .incr          (gen_inc[g])
            );

            wrap_counter #(
                .W(`GEN_CTR_W)
            ) u_ctr (
                .clk_sys  (clk_sys),
                .rst      (rst),
                .load     (msr_wr_en && (msr_addr == `ADDR_CTR_BASE + g)),
                .load_val (msr_wdata[47:0]),
                .inc      (gen_inc[g]),
                .count_r  (gen_count[g])                         // [R1] [R19]
            );
        end
    endgenerate

    // Residency counters have no enable and no freeze path at all
    wrap_counter #(.W(`RES_CTR_W)) u_res_p3 (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .load     (msr_wr_en && (msr_addr == `ADDR_P3_RES)),     // [R15]
        .load_val (msr_wdata),
        .inc      ({4'h0, res_active[0]}),                       // [R13]
        .count_r  (res_count[0])
    );

    wrap_counter #(.W(`RES_CTR_W)) u_res_p6 (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .load     (msr_wr_en && (msr_addr == `ADDR_P6_RES)),     // [R15]
        .load_val (msr_wdata),
        .inc      ({4'h0, res_active[1]}),                       // [R13]
        .count_r  (res_count[1])
    );

    wrap_counter #(.W(`RES_CTR_W)) u_res_s3 (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .load     (msr_wr_en && (msr_addr == `ADDR_SLEEP3_RES)), // [R15]
        .load_val (msr_wdata),
        .inc      ({4'h0, res_active[2]}),                       // [R13]
        .count_r  (res_count[2])
    );

    wrap_counter #(.W(`RES_CTR_W)) u_res_s6 (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .load     (msr_wr_en && (msr_addr == `ADDR_SLEEP6_RES)), // [R15]
        .load_val (msr_wdata),
        .inc      ({4'h0, res_active[3]}),                       // [R13]
        .count_r  (res_count[3])
    );

    // Control and filter registers; unimplemented control bits stay zero
    always @(posedge clk_sys) begin
        if (rst) begin
            for (k = 0; k < 4; k = k + 1) begin
                ctrl_r[k] <= `CTL_RESET;
            end
            band_filter_r <= `BAND_FILTER_RESET;
        end else if (msr_wr_en) begin
            for (k = 0; k < 4; k = k + 1) begin
                if (msr_addr == `ADDR_CTL_BASE + k[11:0]) begin
                    ctrl_r[k] <= msr_wdata[31:0] & `CTL_WR_MASK; // [R1]
                end
            end
            if (msr_addr == `ADDR_BAND_FILTER) begin
                band_filter_r <= msr_wdata[31:0];                // [R10]
            end
        end
    end

    // Read decode; an unmapped address returns zero and flags an error
    always @* begin
        rdata_nxt = 64'h0000000000000000;
        err_nxt   = 1'b0;
        case (msr_addr)
            `ADDR_P3_RES:      rdata_nxt = res_count[0];         // [R15]
            `ADDR_P6_RES:      rdata_nxt = res_count[1];
            `ADDR_SLEEP3_RES:  rdata_nxt = res_count[2];
            `ADDR_SLEEP6_RES:  rdata_nxt = res_count[3];
            `ADDR_BAND_FILTER: rdata_nxt = filt_rd;
            default: begin
                if (in_quad(msr_addr, `ADDR_CTL_BASE)) begin
                    rdata_nxt = {32'h00000000, ctrl_r[msr_addr[1:0]]};
                end else if (in_quad(msr_addr, `ADDR_CTR_BASE)) begin
                    rdata_nxt = {16'h0000, gen_count[msr_addr[1:0]]};
                end else begin
                    err_nxt = 1'b1;
                end
            end
        endcase
    end

    // Read answer registered one cycle after the strobe; writes to bad addresses also flag
    always @(posedge clk_sys) begin
        if (rst) begin
            msr_rdata_r  <= 64'h0000000000000000;
            msr_rvalid_r <= 1'b0;
            msr_err_r    <= 1'b0;
        end else begin
            msr_rvalid_r <= msr_rd_en;
            msr_err_r    <= (msr_rd_en | msr_wr_en) & err_nxt;
            if (msr_rd_en) begin
                msr_rdata_r <= rdata_nxt;
            end
        end
    end

endmodule
`default_nettype wire

// [verif/perf_counters_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "perf_monitor_regs.vh"
module perf_counters_sva (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Register access port
    input wire logic        msr_wr_en,
    input wire logic        msr_rd_en,
    input wire logic [11:0] msr_addr,
    input wire logic [63:0] msr_rdata_r,
    input wire logic        msr_rvalid_r,
    input wire logic        msr_err_r
);
    // Index decode; residency sits at 0x3F8, 0x3F9, 0x3FC and 0x3FD only
    wire logic is_ctl = (msr_addr >= `ADDR_CTL_BASE) && (msr_addr <= `ADDR_CTL_BASE + 12'h003);
    wire logic is_ctr = (msr_addr >= `ADDR_CTR_BASE) && (msr_addr <= `ADDR_CTR_BASE + 12'h003);
    wire logic is_res = (msr_addr[11:3] == 9'h07F) && !msr_addr[1];
    wire logic hit    = is_ctl | is_ctr | is_res | (msr_addr == `ADDR_BAND_FILTER);
    wire logic bad    = (msr_wr_en | msr_rd_en) && !hit;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // The valid pulse answers every read and lasts one cycle for a lone read
    rd_answer_a: assert property (msr_rd_en ##1 !msr_rd_en |-> msr_rvalid_r ##1 !msr_rvalid_r)
        else $error("read valid not a single pulse");
    rd_quiet_a: assert property (!msr_rd_en |=> !msr_rvalid_r)
        else $error("read valid without a read");
    miss_err_a: assert property (bad |=> msr_err_r)
        else $error("unmapped access without error");
    hit_clean_a: assert property (!bad |=> !msr_err_r)
        else $error("error without unmapped access");
    miss_zero_a: assert property (msr_rd_en && bad |=> msr_rdata_r == 64'h0000000000000000)
        else $error("unmapped read not zero");
    data_hold_a: assert property (!msr_rd_en |=> $stable(msr_rdata_r))
        else $error("read data changed without a read");
    filt_top_a: assert property (msr_rd_en && msr_addr == `ADDR_BAND_FILTER |=> msr_rdata_r[63:32] == 32'h00000000)
        else $error("filter upper half not zero");
    ctl_bits_a: assert property (msr_rd_en && is_ctl |=> (msr_rdata_r & ~{32'h00000000, `CTL_WR_MASK}) == 64'h0)
        else $error("control undefined bits set");

    // Main scenarios
    cover property (msr_rd_en && is_res);
    cover property (bad);
    cover property (msr_wr_en && is_ctl);
endmodule

bind power_ctrl_perf_counters perf_counters_sva chk (
    .clk_sys(clk_sys), .rst(rst), .msr_wr_en(msr_wr_en), .msr_rd_en(msr_rd_en), .msr_addr(msr_addr),
    .msr_rdata_r(msr_rdata_r), .msr_rvalid_r(msr_rvalid_r), .msr_err_r(msr_err_r)
);
`default_nettype wire

// [verif/occ_source.sv]
`timescale 1ns/1ps
`default_nettype none
module occ_source (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Bench control
    input  wire logic [4:0]  level,
    input  wire logic [1:0]  sleep_on,
    // Towards the counter block
    output var  logic [14:0] occ_values,
    output var  logic [7:0]  cores_in_sleep3,
    output var  logic [7:0]  cores_in_sleep6
);
    integer     seed = 69;
    logic [7:0] pick;
    // Registered hand-off like the microcontroller; source 2 churns and source 3 holds the inverted level so a wrong select shows
    always @(posedge clk_sys) begin
        pick <= 8'($random(seed));
        if (rst) begin
            occ_values      <= 15'h0000;
            cores_in_sleep3 <= 8'h00;
            cores_in_sleep6 <= 8'h00;
        end else begin
            occ_values      <= {~level, pick[4:0], level};
            // A varying, nonzero set of cores; residency must not follow their number
            cores_in_sleep3 <= sleep_on[0] ? (pick | 8'h01) : 8'h00;
            cores_in_sleep6 <= sleep_on[1] ? (pick | 8'h80) : 8'h00;
        end
    end
endmodule
`default_nettype wire

// [verif/power_ctrl_perf_counters_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "perf_monitor_regs.vh"
module power_ctrl_perf_counters_test;
    localparam logic [31:0] EN   = 32'h00400000;
    localparam logic [31:0] OSEL = 32'h00004080;
    localparam logic [31:0] EDG  = 32'h00040000;
    localparam logic [31:0] INV  = 32'h40000000;
    localparam logic [31:0] OEDG = 32'h80000000;
    localparam logic [31:0] THR5 = 32'h05000000;
    // Unmapped indices next to each mapped group
    function automatic logic [11:0] hole_a(input integer j);
        hole_a = (j == 0) ? 12'h3FA : (j == 1) ? 12'h704 : (j == 2) ? 12'h70C : 12'h711;
    endfunction
    logic         clk_sys, rst, msr_wr_en, msr_rd_en, msr_rvalid_r, msr_err_r, p_state3_active, p_state6_active;
    logic [11:0]  msr_addr;
    logic [63:0]  msr_wdata, msr_rdata_r, d, q, w;
    logic [127:0] simple_events;
    logic [14:0]  occ_values;
    logic [7:0]   freq_ratio, cores_in_sleep3, cores_in_sleep6;
    logic [4:0]   level;
    logic [1:0]   sleep_on;
    logic         v_q, e_q;
    integer       seed, err_count, n_tests, i, k, n;

    power_ctrl_perf_counters uut (
        .clk_sys(clk_sys), .rst(rst), .msr_wr_en(msr_wr_en), .msr_rd_en(msr_rd_en), .msr_addr(msr_addr),
        .msr_wdata(msr_wdata), .msr_rdata_r(msr_rdata_r), .msr_rvalid_r(msr_rvalid_r), .msr_err_r(msr_err_r),
        .simple_events(simple_events), .occ_values(occ_values), .freq_ratio(freq_ratio),
        .p_state3_active(p_state3_active), .p_state6_active(p_state6_active),
        .cores_in_sleep3(cores_in_sleep3), .cores_in_sleep6(cores_in_sleep6)
    );
    occ_source src (
        .clk_sys(clk_sys), .rst(rst), .level(level), .sleep_on(sleep_on), .occ_values(occ_values),
        .cores_in_sleep3(cores_in_sleep3), .cores_in_sleep6(cores_in_sleep6)
    );

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One access; answers are taken mid-cycle, where they have settled
    task automatic acc(input logic wr, input logic [11:0] a, input logic [63:0] wd);
        msr_wr_en <= wr;
        msr_rd_en <= !wr;
        msr_addr  <= a;
        msr_wdata <= wd;
        @(posedge clk_sys);
        msr_wr_en <= 1'b0;
        msr_rd_en <= 1'b0;
        @(negedge clk_sys);
        q   = msr_rdata_r;
        v_q = msr_rvalid_r;
        e_q = msr_err_r;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [11:0] a, input logic [63:0] e);
        acc(1'b0, a, 64'h0);
        chk("rdata", e, q);
        chk("flags", 64'h2, {62'h0, v_q, e_q});
    endtask
    function automatic logic [63:0] grow(input logic [63:0] b, input integer c, input logic wide);
        grow = wide ? b + 64'(c) : {16'h0000, b[47:0] + 48'(c)};
    endfunction
    function automatic logic [11:0] res_a(input integer j);
        res_a = (j < 2) ? `ADDR_P3_RES + 12'(j) : `ADDR_SLEEP3_RES + 12'(j - 2);
    endfunction
    // Program a counter, preset it, change the sources, count; per < 0 means one single count
    task automatic meas(input integer c, input logic [31:0] ctl, input logic [4:0] lv, input logic [127:0] ev,
                        input integer per, input logic fix);
        w = {$random(seed), $random(seed)};
        d = fix ? 64'h0000FFFFFFFFFFFD : {16'h0000, w[47:0]};
        n = 4 + ($random(seed) & 3);
        acc(1'b1, `ADDR_CTL_BASE + 12'(c), {32'h0, ctl});
        acc(1'b1, `ADDR_CTR_BASE + 12'(c), d);
        level <= lv;
        simple_events <= ev;
        repeat (n) @(posedge clk_sys);
        rd(`ADDR_CTR_BASE + 12'(c), grow(d, per < 0 ? 1 : per * (n + 1), 1'b0));
    endtask

    task automatic results;
        $display("TB: errors %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_count = err_count + 1;
        results;
    end

    initial begin
        {seed, err_count, n_tests} = {32'd69, 32'd0, 32'd0};
        {rst, msr_wr_en, msr_rd_en, msr_addr, msr_wdata} = {3'b100, 12'h000, 64'h0};
        {simple_events, freq_ratio, level, sleep_on, p_state3_active, p_state6_active} = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        // Everything reads zero out of reset
        for (i = 0; i < 4; i = i + 1) begin
            rd(res_a(i), 64'h0);
            rd(`ADDR_CTL_BASE + 12'(i), 64'h0);
            rd(`ADDR_CTR_BASE + 12'(i), 64'h0);
        end
        rd(`ADDR_BAND_FILTER, 64'h0);
        // Holes in the map: reads and writes both flag an error, reads return zero
        for (i = 0; i < 4; i = i + 1) begin
            acc(i[0], hole_a(i), 64'hFFFFFFFFFFFFFFFF);
            chk("err", 64'h1, {63'h0, e_q});
            chk("hole", 64'h0, q);
        end
        // Only defined bits survive a write, all-ones first
        for (i = 0; i < 4; i = i + 1) begin
            w = (i == 0) ? 64'hFFFFFFFFFFFFFFFF : {$random(seed), $random(seed)};
            acc(1'b1, `ADDR_CTL_BASE + 12'(i), w);
            rd(`ADDR_CTL_BASE + 12'(i), w & {32'h0, `CTL_WR_MASK});
            acc(1'b1, `ADDR_BAND_FILTER, w);
            rd(`ADDR_BAND_FILTER, w & `BAND_FILTER_MASK);
        end
        // Residency follows its own state input only, whatever the monitor controls hold
        for (k = 0; k < 2; k = k + 1) begin
            p_state3_active <= !k[0];
            p_state6_active <= k[0];
            sleep_on <= k[0] ? 2'b10 : 2'b01;
            for (i = 0; i < 4; i = i + 1) begin
                w = (i == 0) ? 64'hFFFFFFFFFFFFFFFE : {$random(seed), $random(seed)};
                n = $random(seed) & 7;
                acc(1'b1, res_a(i), w);
                repeat (n) @(posedge clk_sys);
                rd(res_a(i), grow(w, (i[0] == k[0]) ? n + 1 : 0, 1'b1));
            end
        end
        sleep_on <= 2'b00;
        meas(3, EN, 5'h00, 128'h0, 1, 1'b1);
        meas(2, 32'h0, 5'h00, 128'h0, 0, 1'b0);
        // Raw occupancy adds the whole value on every counter; odd counters take the third source
        for (i = 0; i < 4; i = i + 1) begin
            k = ($random(seed) & 7) + 1;
            level <= 5'(k);
            meas(i, EN | OSEL | (i[0] ? 32'h00008000 : 32'h0), 5'(k), 128'h0, i[0] ? 31 - k : k, 1'b0);
        end
        // No occupancy source selected adds nothing
        meas(0, EN | 32'h00000080, 5'h03, 128'h0, 0, 1'b0);
        // Threshold compare at the boundary, plain and inverted
        for (i = 0; i < 4; i = i + 1) begin
            level <= i[0] ? 5'h05 : 5'h04;
            meas(0, EN | OSEL | THR5 | (i[1] ? INV : 32'h0), i[0] ? 5'h05 : 5'h04, 128'h0, i[0] ^ i[1], 1'b0);
        end
        // One step up or down under occupancy edge detect
        for (i = 0; i < 4; i = i + 1) begin
            level <= i[0] ? 5'h00 : 5'h05;
            meas(1, EN | OSEL | THR5 | OEDG | (i[1] ? INV : 32'h0), i[0] ? 5'h05 : 5'h00, 128'h0,
                 (i[0] ^ i[1]) ? -1 : 0, 1'b0);
        end
        meas(2, EN | EDG | 32'h03, 5'h00, 128'h8, -1, 1'b0);
        meas(3, EN | INV | OEDG | THR5 | 32'h03, 5'h00, 128'h8, 1, 1'b0);
        // Four bands at once; 0x25 is 3.7 GHz and band 1 sits exactly on it
        acc(1'b1, `ADDR_BAND_FILTER, 64'h0000000040302510);
        freq_ratio <= 8'h25;
        for (i = 0; i < 4; i = i + 1)
            meas(i, EN | (32'(`EV_BAND0) + 32'(i)), 5'h00, 128'h0, i < 2, 1'b0);
        results;
    end
endmodule
`default_nettype wire
